/* hdl/bsm_pkg.sv */
// Constants, types and the strap synchroniser for boot strap mode selection.
// Assumes one 125 MHz clock; strap and receive pins are asynchronous to it.

package bsm_pkg;

    // ****************************************************************
    // Strap codes, bit 2 first
    // ****************************************************************
    localparam logic [2:0] SERIAL_LOAD_CODE = 3'h4;
    localparam logic [2:0] TWO_WIRE_RUN_CODE = 3'h1;
    localparam logic [2:0] FOUR_WIRE_RUN_CODE = 3'h0;
    localparam logic [2:0] BREAK_DETECT_CODE = 3'h2;
    localparam logic [2:0] FACTORY_RESTORE_CODE = 3'h3;
    localparam logic [2:0] FACTORY_RESTORE_ALT_CODE = 3'h6;
    localparam logic [2:0] STRAP_RESET = 3'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint CLK_HZ = 125_000_000;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    localparam longint RESTORE_MIN_S = 8;
    localparam int unsigned RESTORE_MIN_CYCLES = int'(RESTORE_MIN_S * CLK_HZ);
    localparam longint BREAK_TIME_US = 20;
    localparam int unsigned BREAK_CYCLES_DEF = int'((BREAK_TIME_US * CLK_HZ) / 1_000_000);

    // ****************************************************************
    // Serial flash sectors
    // ****************************************************************
    localparam int unsigned SECTOR_W = 8;
    localparam logic [SECTOR_W-1:0] PROT_SECTOR_DEF = 8'h00;

    typedef enum logic [1:0] {
        RK_NONE = 2'h0,
        RK_PARAMS = 2'h1,
        RK_IMAGE_PARAMS = 2'h2
    } bsm_restore_kind_t;

    typedef struct packed {
        logic [2:0] code;
        logic [2:0] alt_en;
        logic jtag4;
        logic swd2;
        logic uart_loader;
        logic run;
    } bsm_boot_cfg_t;

    localparam bsm_boot_cfg_t BOOT_CFG_RESET = '0;

endpackage

`timescale 1ns/1ps
`default_nettype none

module bsm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // Only the second stage reads the first
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // bsm_sync

`default_nettype wire

/* hdl/bsm_boot_strap_mode_select.sv */
// Boot strap mode selection and factory restore trigger.
// Assumes NRST_I is the reset pin already held long enough by the reset source.

`timescale 1ns/1ps
`default_nettype none

module bsm_boot_strap_mode_select
    import bsm_pkg::*;
#(
    parameter int unsigned RESTORE_LIMIT_CYCLES = RESTORE_MIN_CYCLES,
    parameter int unsigned BREAK_CYCLES = BREAK_CYCLES_DEF,
    parameter logic [2:0] RESTORE_CODE = FACTORY_RESTORE_CODE,
    parameter logic [SECTOR_W-1:0] PROTECTED_SECTOR = PROT_SECTOR_DEF
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] BOOT_STRAP_PINS_I,
    input wire logic UART_RX_I,
    input wire logic [1:0] RESTORE_SEL_I,
    input wire logic [1:0] RESTORE_PEND_I,
    input wire logic RESTORE_DONE_I,
    input wire logic HOST_FLASH_REQ_I,
    input wire logic [SECTOR_W-1:0] HOST_FLASH_SECTOR_I,
    output bsm_boot_cfg_t BOOT_CFG_O,
    output logic STRAP_VALID_O,
    output logic RESTORE_START_O,
    output logic RESTORE_BUSY_O,
    output logic [1:0] RESTORE_KIND_O,
    output logic [1:0] RESTORE_PEND_O,
    output logic RESTORE_TIMEOUT_O,
    output logic HOST_FLASH_GNT_O,
    output logic HOST_FLASH_DENY_O
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (RESTORE_LIMIT_CYCLES < 1) begin : g_bad_limit
        $error("RESTORE_LIMIT_CYCLES must be at least one");
    end
    if (BREAK_CYCLES < 1) begin : g_bad_break
        $error("BREAK_CYCLES must be at least one");
    end

    typedef enum {ST_SETTLE, ST_DECODE, ST_BREAK, ST_LOAD, ST_RUN, ST_RESTORE} bsm_state_t;

    bsm_state_t state;
    logic [2:0] strap_sync;
    logic rx_sync;
    logic [2:0] strap;
    logic [1:0] settle_cnt;
    logic [31:0] break_cnt;
    logic [31:0] restore_cnt;
    logic restore_end;
    logic go_restore;
    logic [1:0] next_kind;
    bsm_boot_cfg_t next_cfg;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    bsm_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .async_i({UART_RX_I, BOOT_STRAP_PINS_I}),
        .sync_o({rx_sync, strap_sync})
    );

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            settle_cnt <= '0;
        end else if (settle_cnt != SETTLE_CYCLES) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            strap <= STRAP_RESET;
            STRAP_VALID_O <= 1'b0;
        end else if (state == ST_SETTLE && settle_cnt == SETTLE_CYCLES) begin
            strap <= strap_sync;
            STRAP_VALID_O <= 1'b1;
        end
    end

    // ****************************************************************
    // Boot flow
    // ****************************************************************
    assign go_restore = (RESTORE_PEND_I != RK_NONE) ||
        (strap == RESTORE_CODE && RESTORE_SEL_I != RK_NONE);
    assign next_kind = (RESTORE_PEND_I != RK_NONE) ? RESTORE_PEND_I : RESTORE_SEL_I;
    assign restore_end = RESTORE_DONE_I || (restore_cnt == RESTORE_LIMIT_CYCLES - 1);

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state <= ST_SETTLE;
        end else begin
            unique case (state)
                ST_SETTLE: begin
                    if (settle_cnt == SETTLE_CYCLES) begin
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    if (go_restore) begin
                        state <= ST_RESTORE;
                    end else if (strap == SERIAL_LOAD_CODE) begin
                        state <= ST_LOAD;
                    end else if (strap == BREAK_DETECT_CODE) begin
                        state <= ST_BREAK;
                    end else begin
                        state <= ST_RUN;
                    end
                end
                ST_BREAK: begin
                    if (rx_sync) begin
                        state <= ST_RUN;
                    end else if (break_cnt == BREAK_CYCLES - 1) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state <= ST_LOAD;
                end
                ST_RESTORE: begin
                    if (restore_end) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // Break and restore timers
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || state != ST_BREAK) begin
            break_cnt <= '0;
        end else begin
            break_cnt <= break_cnt + 32'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I || state != ST_RESTORE) begin
            restore_cnt <= '0;
        end else begin
            restore_cnt <= restore_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Restore control
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RESTORE_START_O <= 1'b0;
            RESTORE_BUSY_O <= 1'b0;
            RESTORE_KIND_O <= RK_NONE;
            RESTORE_PEND_O <= RK_NONE;
            RESTORE_TIMEOUT_O <= 1'b0;
        end else begin
            RESTORE_START_O <= (state == ST_DECODE) && go_restore;
            if (state == ST_DECODE && go_restore) begin
                RESTORE_BUSY_O <= 1'b1;
                RESTORE_KIND_O <= next_kind;
                RESTORE_PEND_O <= next_kind;
            end else if (state == ST_RESTORE && restore_end) begin
                RESTORE_BUSY_O <= 1'b0;
                RESTORE_PEND_O <= RESTORE_DONE_I ? RK_NONE : RESTORE_PEND_O;
                RESTORE_TIMEOUT_O <= !RESTORE_DONE_I;
            end
        end
    end

    // ****************************************************************
    // Pin mapping
    // ****************************************************************
    always_comb begin
        next_cfg = BOOT_CFG_RESET;
        next_cfg.code = strap;
        next_cfg.alt_en = {STRAP_VALID_O, 2'h0};
        unique case (state)
            ST_SETTLE, ST_DECODE: begin
                next_cfg.jtag4 = 1'b0;
            end
            ST_LOAD: begin
                next_cfg.jtag4 = 1'b1;
                next_cfg.uart_loader = 1'b1;
            end
            ST_BREAK, ST_RESTORE: begin
                next_cfg.jtag4 = 1'b1;
            end
            ST_RUN: begin
                next_cfg.run = 1'b1;
                next_cfg.swd2 = (strap == TWO_WIRE_RUN_CODE);
                next_cfg.jtag4 = (strap != TWO_WIRE_RUN_CODE);
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            BOOT_CFG_O <= BOOT_CFG_RESET;
        end else begin
            BOOT_CFG_O <= next_cfg;
        end
    end

    // ****************************************************************
    // Host flash guard
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            HOST_FLASH_GNT_O <= 1'b0;
            HOST_FLASH_DENY_O <= 1'b0;
        end else begin
            HOST_FLASH_GNT_O <= HOST_FLASH_REQ_I && (HOST_FLASH_SECTOR_I != PROTECTED_SECTOR);
            HOST_FLASH_DENY_O <= HOST_FLASH_REQ_I &&
                (HOST_FLASH_SECTOR_I == PROTECTED_SECTOR);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    a_strap_held: assert property (STRAP_VALID_O && $past(STRAP_VALID_O) |->
        $stable(strap)) else $error("strap register changed after capture");
    a_strap_capture: assert property ($rose(STRAP_VALID_O) |->
        strap == $past(strap_sync)) else $error("strap not taken from pins");
    a_load_forever: assert property (state == ST_LOAD |=>
        state == ST_LOAD) else $error("serial load exited");
    a_load_pins: assert property (state == ST_LOAD |=>
        BOOT_CFG_O.uart_loader && BOOT_CFG_O.jtag4) else $error("load mapping wrong");
    a_swd_map: assert property (state == ST_RUN && strap == TWO_WIRE_RUN_CODE |=>
        BOOT_CFG_O.swd2 && !BOOT_CFG_O.jtag4) else $error("two-wire mapping wrong");
    a_jtag_map: assert property (state == ST_RUN && strap != TWO_WIRE_RUN_CODE |=>
        BOOT_CFG_O.jtag4 && !BOOT_CFG_O.swd2) else $error("four-wire mapping wrong");
    a_break_load: assert property (state == ST_BREAK && !rx_sync &&
        break_cnt == BREAK_CYCLES - 1 |=> state == ST_LOAD) else $error("break missed");
    a_break_run: assert property (state == ST_BREAK && rx_sync |=>
        state == ST_RUN) else $error("idle line did not run");
    a_restore_start: assert property (state == ST_DECODE && go_restore |=>
        RESTORE_START_O && RESTORE_BUSY_O ##1 !RESTORE_START_O)
        else $error("restore start wrong");
    a_restore_kind: assert property ($rose(RESTORE_BUSY_O) |->
        RESTORE_KIND_O == RESTORE_PEND_O && RESTORE_KIND_O != RK_NONE)
        else $error("restore kind not kept");
    a_pend_kept: assert property (RESTORE_BUSY_O && !RESTORE_DONE_I |=>
        RESTORE_PEND_O != RK_NONE) else $error("pending lost early");
    a_restore_min: assert property ($rose(RESTORE_TIMEOUT_O) |->
        $past(restore_cnt) == RESTORE_LIMIT_CYCLES - 1) else $error("timeout early");
    a_sector_guard: assert property (HOST_FLASH_REQ_I &&
        HOST_FLASH_SECTOR_I == PROTECTED_SECTOR |=> HOST_FLASH_DENY_O && !HOST_FLASH_GNT_O)
        else $error("protected sector granted");
    a_pins01_kept: assert property (BOOT_CFG_O.alt_en[1:0] == 2'h0)
        else $error("strap pin 0 or 1 offered");
    a_reserved_run: assert property (state == ST_DECODE && !go_restore &&
        strap inside {3'h5, 3'h6, 3'h7} |=> state == ST_RUN) else $error("reserved code");

    c_serial_load: cover property (state == ST_DECODE ##1 state == ST_LOAD);
    c_break_run: cover property (state == ST_BREAK ##1 state == ST_RUN);
    c_restore_done: cover property (RESTORE_BUSY_O ##1 !RESTORE_BUSY_O && !RESTORE_TIMEOUT_O);
    c_denied: cover property (HOST_FLASH_DENY_O);

endmodule // bsm_boot_strap_mode_select

`default_nettype wire

/* bench/bsm_board_model.sv */
// Board side model: strap resistors, receive line and restore engine.
// Assumes the bench sets the wanted strap code, break level and restore delay.
`timescale 1ns/1ps
`default_nettype none
module bsm_board_model
    import bsm_pkg::*;
(
    input wire logic clk_i,
    input wire logic [2:0] strap_code_i,
    input wire logic break_i,
    input wire logic [7:0] done_dly_i,
    input wire bsm_boot_cfg_t cfg_i,
    input wire logic start_i,
    output logic [2:0] pins_o,
    output logic rx_o,
    output logic done_o
);
    logic [7:0] cnt = 8'h0;
    logic armed = 1'b0;
    // Pin 2 turns into a toggling output once the device frees it
    always @(negedge clk_i) begin
        pins_o[1:0] <= strap_code_i[1:0];
        pins_o[2] <= cfg_i.alt_en[2] ? ~pins_o[2] : strap_code_i[2];
        rx_o <= ~break_i;
    end
    // Restore engine: zero delay never finishes
    always @(negedge clk_i) begin
        if (start_i) begin
            armed <= (done_dly_i != 8'h0);
            cnt <= done_dly_i;
        end else if (armed && cnt != 8'h0) begin
            cnt <= cnt - 8'h1;
        end
        done_o <= armed && !start_i && cnt == 8'h1;
        if (done_o) begin
            armed <= 1'b0;
        end
    end
endmodule // bsm_board_model
`default_nettype wire

/* bench/boot_strap_mode_select_bench.sv */
// Self-checking bench for boot strap mode selection.
// Assumes the design package, design and board model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module boot_strap_mode_select_bench;
    import bsm_pkg::*;
    localparam int LIM = 50;
    logic CLK_I = 1'b0;
    logic NRST_I = 1'b0;
    logic [2:0] code = 3'h0;
    logic brk = 1'b0;
    logic [7:0] dly = 8'h0;
    logic [1:0] sel = 2'h0;
    logic [1:0] pend = 2'h0;
    logic req = 1'b0;
    logic [7:0] sec = 8'h0;
    logic [2:0] pins, rc;
    logic rx, done, v, st, busy, tmo, gnt, deny;
    logic [1:0] kind, pend_o, k;
    bsm_boot_cfg_t cfg;
    int err_total = 0;
    int tests_run = 0;
    int n, e;
    int exp_q[$];
    always #4 CLK_I = ~CLK_I;

    bsm_boot_strap_mode_select #(.RESTORE_LIMIT_CYCLES(LIM), .BREAK_CYCLES(8)) dut (
        .CLK_I(CLK_I), .NRST_I(NRST_I), .BOOT_STRAP_PINS_I(pins), .UART_RX_I(rx),
        .RESTORE_SEL_I(sel), .RESTORE_PEND_I(pend), .RESTORE_DONE_I(done),
        .HOST_FLASH_REQ_I(req), .HOST_FLASH_SECTOR_I(sec), .BOOT_CFG_O(cfg),
        .STRAP_VALID_O(v), .RESTORE_START_O(st), .RESTORE_BUSY_O(busy),
        .RESTORE_KIND_O(kind), .RESTORE_PEND_O(pend_o), .RESTORE_TIMEOUT_O(tmo),
        .HOST_FLASH_GNT_O(gnt), .HOST_FLASH_DENY_O(deny));
    bsm_board_model board (.clk_i(CLK_I), .strap_code_i(code), .break_i(brk),
        .done_dly_i(dly), .cfg_i(cfg), .start_i(st), .pins_o(pins), .rx_o(rx),
        .done_o(done));

    // ****************************************************************
    // Reference model and helpers
    // ****************************************************************
    function automatic bsm_boot_cfg_t exp_cfg(input logic [2:0] c, input bit b);
        bsm_boot_cfg_t x;
        x = '0;
        x.code = c;
        x.alt_en = 3'h4;
        x.jtag4 = 1'b1;
        x.run = 1'b1;
        if (c == TWO_WIRE_RUN_CODE) begin
            x.jtag4 = 1'b0;
            x.swd2 = 1'b1;
        end
        if (c == SERIAL_LOAD_CODE || (c == BREAK_DETECT_CODE && b)) begin
            x.run = 1'b0;
            x.uart_loader = 1'b1;
        end
        return x;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge CLK_I);
    endtask
    task automatic boot(input logic [2:0] c, input logic [1:0] s, input logic [1:0] p);
        @(negedge CLK_I);
        NRST_I = 1'b0;
        code = c;
        sel = s;
        pend = p;
        cyc(6);
        check("cfg in reset", 16'(cfg), 16'h0);
        check("valid in reset", 16'({v, st, busy}), 16'h0);
        NRST_I = 1'b1;
        n = 0;
        while (v !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 10) begin
                err_total++;
                close_out();
            end
        end
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (100000) @(posedge CLK_I);
        err_total++;
        close_out();
    end
    initial begin
        void'($urandom(32'h1da5add8));
        for (int c = 0; c < 8; c++) begin
            boot(3'(c), 2'h0, 2'h0);
            cyc(4);
            check("cfg", 16'(cfg), 16'(exp_cfg(3'(c), 1'b0)));
            code = 3'($urandom);
            cyc(4);
            check("cfg held", 16'(cfg), 16'(exp_cfg(3'(c), 1'b0)));
            check("no restore", 16'({st, busy, tmo}), 16'h0);
            $display("strap code %0d done", c);
        end
        for (int i = 0; i < 40; i++) begin
            req = 1'($urandom);
            sec = 8'($urandom % 4);
            exp_q.push_back(req ? ((sec == PROT_SECTOR_DEF) ? 2 : 1) : 0);
            cyc(1);
            e = exp_q.pop_front();
            check("grant", 16'(gnt), 16'(e == 1));
            check("deny", 16'(deny), 16'(e == 2));
        end
        req = 1'b0;
        $display("host flash done");
        brk = 1'b1;
        boot(BREAK_DETECT_CODE, 2'h0, 2'h0);
        cyc(14);
        check("break load", 16'(cfg), 16'(exp_cfg(BREAK_DETECT_CODE, 1'b1)));
        brk = 1'b0;
        cyc(20);
        check("load kept", 16'(cfg), 16'(exp_cfg(BREAK_DETECT_CODE, 1'b1)));
        $display("break detect done");
        for (int t = 0; t < 3; t++) begin
            dly = (t == 1) ? 8'h0 : 8'(5 + $urandom % 30);
            rc = (t == 2) ? 3'h0 : FACTORY_RESTORE_CODE;
            k = (t == 2) ? 2'h2 : 2'(t + 1);
            boot(rc, (t == 2) ? 2'h0 : k, (t == 2) ? k : 2'h0);
            cyc(1);
            check("start", 16'({st, busy, kind, pend_o}), 16'({2'h3, k, k}));
            cyc(1);
            check("start pulse", 16'(st), 16'h0);
            n = 2;
            while (busy === 1'b1 && n < 300) begin
                cyc(1);
                n++;
            end
            if (n >= 300) begin
                err_total++;
                close_out();
            end
            e = (dly == 8'h0) ? LIM : int'(dly);
            check("restore length", 16'(n >= e && n <= e + 4), 16'h1);
            check("timeout", 16'(tmo), 16'(dly == 8'h0));
            check("pending", 16'(pend_o), 16'((dly == 8'h0) ? k : 2'h0));
            cyc(2);
            check("run after", 16'(cfg), 16'(exp_cfg(rc, 1'b0)));
            $display("restore case %0d done", t);
        end
        close_out();
    end
endmodule // boot_strap_mode_select_bench
`default_nettype wire
